// ==== hw/nvts_top.sv ====
// timekeeping sram: byte array with a bcd clock in the top eight bytes
// assumes async sram pins from a host, sampled on a 50 mhz clock
`timescale 1ns/10ps
`include "nvts_defines.svh"

module nvts_top
#(
    // cycles per second tick, shorten for simulation
    parameter int TICK_CYCLES = `NVTS_TICK_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host sram strobes, active low
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    // host address
    input wire logic [`NVTS_ADDR_W-1:0] location_lines,
    // host data, split two-way pin
    input wire logic [`NVTS_DATA_W-1:0] byte_lines_in,
    output logic [`NVTS_DATA_W-1:0] byte_lines_out,
    output logic byte_lines_oe_n,
    // supply monitor
    input wire logic supply_good,
    output logic supply_fail_out_n
);
    import nvts_pkg::*;

    // ==========================================================
    // functions

    // bits owned by the clock at a given index; the rest are storage
    function automatic logic [7:0] clk_mask(input logic [2:0] idx);
        case (idx)
            `NVTS_IDX_CTRL: clk_mask = 8'hFF;
            `NVTS_IDX_SEC: clk_mask = `NVTS_MASK_SEC;
            `NVTS_IDX_MIN: clk_mask = `NVTS_MASK_MIN;
            `NVTS_IDX_HOUR: clk_mask = `NVTS_MASK_HOUR;
            `NVTS_IDX_DAY: clk_mask = `NVTS_MASK_DAY;
            `NVTS_IDX_DATE: clk_mask = `NVTS_MASK_DATE;
            `NVTS_IDX_MONTH: clk_mask = `NVTS_MASK_MONTH;
            default: clk_mask = `NVTS_MASK_YEAR;
        endcase
    endfunction

    // true when a location is one of the top eight
    function automatic logic is_clk(input logic [`NVTS_ADDR_W-1:0] a);
        is_clk = (a[`NVTS_ADDR_W-1:3] == `NVTS_CLK_TOP);
    endfunction

    // bcd step with wrap from last back to first
    function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        if (v == last)
            bcd_next = first;
        else if (v[3:0] == 4'h9)
            bcd_next = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_next = {v[7:4], v[3:0] + 4'h1};
    endfunction

    // last date of a month; bcd years 00-99, 00 taken as 2000 (leap)
    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    endfunction

    // ==========================================================
    // pin synchronisers

    logic [1:0] ce_sync, oe_sync, we_sync, good_sync; // two stages each
    logic [`NVTS_ADDR_W-1:0] addr_meta, addr_s; // address stages
    logic [`NVTS_DATA_W-1:0] din_meta, din_s; // data stages

    // every pin passes two flops before logic reads it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ce_sync <= 2'h3;
            oe_sync <= 2'h3;
            we_sync <= 2'h3;
            good_sync <= 2'h0;
            addr_meta <= 17'h00000;
            addr_s <= 17'h00000;
            din_meta <= 8'h00;
            din_s <= 8'h00;
        end
        else
        begin
            ce_sync <= {ce_sync[0], ce_n};
            oe_sync <= {oe_sync[0], oe_n};
            we_sync <= {we_sync[0], we_n};
            good_sync <= {good_sync[0], supply_good};
            addr_meta <= location_lines;
            addr_s <= addr_meta;
            din_meta <= byte_lines_in;
            din_s <= din_meta;
        end
    end

    // ==========================================================
    // access decode

    logic good; // supply within tolerance
    logic sel; // selected, gated by supply
    logic wr_act; // write strobe and select both active
    logic rd_drive; // read with outputs enabled
    logic wr_act_q; // previous write state
    logic wr_commit; // one-cycle pulse at end of write
    nvts_access_t wr_hold; // address and data latched during the write

    assign good = good_sync[1];
    assign sel = ~ce_sync[1] & good;
    assign wr_act = sel & ~we_sync[1];
    assign rd_drive = sel & we_sync[1] & ~oe_sync[1];
    // a write lands when the strobes end, with data sampled just before
    assign wr_commit = wr_act_q & ~wr_act & good;

    // follow the write and keep its last sampled address and data
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_act_q <= 1'b0;
            wr_hold <= '0;
        end
        else
        begin
            wr_act_q <= wr_act;
            if (wr_act)
            begin
                wr_hold <= '{addr: addr_s, data: din_s};
            end
        end
    end

    // ==========================================================
    // storage array

    logic [`NVTS_DATA_W-1:0] mem_rd; // array read data
    logic [`NVTS_ADDR_W-1:0] addr_d; // address that mem_rd belongs to

    // every location is written, so unassigned clock bits are storage
    nvts_mem u_mem
    (
        .clock(clock),
        .wr_en(wr_commit),
        .wr(wr_hold),
        .rd_addr(addr_s),
        .rd_data(mem_rd)
    );

    // ==========================================================
    // control register

    logic [7:0] ctrl; // host control byte
    logic ctrl_whalt_q; // write-halt one cycle ago
    logic clk_wr; // write lands in the clock block
    logic [2:0] clk_idx; // index of that write

    assign clk_wr = wr_commit & is_clk(wr_hold.addr);
    assign clk_idx = wr_hold.addr[2:0];

    // control is updated the cycle the write lands and reads back as written
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `NVTS_CTRL_RESET;
            ctrl_whalt_q <= 1'b0;
        end
        else
        begin
            ctrl_whalt_q <= ctrl[`NVTS_CTRL_WHALT];
            if (clk_wr && clk_idx == `NVTS_IDX_CTRL)
            begin
                ctrl <= wr_hold.data;
            end
        end
    end

    // ==========================================================
    // one second tick

    logic [31:0] tick_cnt; // cycle counter
    logic tick; // one-cycle pulse each second

    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // free-running divider, never stopped by host accesses
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= 32'h00000000;
        else if (tick)
            tick_cnt <= 32'h00000000;
        else
            tick_cnt <= tick_cnt + 32'h00000001;
    end

    // ==========================================================
    // internal counters

    nvts_time_t cnt; // running time, never seen by the host directly
    nvts_time_t hold; // holding registers the host reads and loads
    nvts_time_t next_cnt; // counter value after one second
    logic load_cnt; // write-halt just cleared

    assign load_cnt = ctrl_whalt_q & ~ctrl[`NVTS_CTRL_WHALT];

    // ripple carry through the bcd fields
    always_comb
    begin
        next_cnt = cnt;
        next_cnt.sec = bcd_next(cnt.sec, 8'h59, 8'h00);
        if (cnt.sec == 8'h59)
        begin
            next_cnt.min = bcd_next(cnt.min, 8'h59, 8'h00);
            if (cnt.min == 8'h59)
            begin
                next_cnt.hour = bcd_next(cnt.hour, 8'h23, 8'h00);
                if (cnt.hour == 8'h23)
                begin
                    next_cnt.day = bcd_next(cnt.day, 8'h07, 8'h01);
                    next_cnt.date = bcd_next(cnt.date, month_last(cnt.month, cnt.year), 8'h01);
                    if (cnt.date == month_last(cnt.month, cnt.year))
                    begin
                        next_cnt.month = bcd_next(cnt.month, 8'h12, 8'h01);
                        if (cnt.month == 8'h12)
                            next_cnt.year = bcd_next(cnt.year, 8'h99, 8'h00);
                    end
                end
            end
        end
    end

    // counters load from holding when write-halt clears, else count each tick while write-halt is clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= `NVTS_TIME_RESET;
        else if (load_cnt)
            cnt <= hold;
        else if (tick && !ctrl[`NVTS_CTRL_WHALT])
            cnt <= next_cnt;
    end

    // ==========================================================
    // holding registers

    logic halted; // either halt bit set
    logic [7:0] wmask; // clock bits of the written location

    assign halted = ctrl[`NVTS_CTRL_RHALT] | ctrl[`NVTS_CTRL_WHALT];
    assign wmask = clk_mask(clk_idx);

    // copy every cycle while running; frozen and loadable while halted
    // skip the copy on the load edge, or the old count would show a cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hold <= `NVTS_TIME_RESET;
        else if (!halted && !load_cnt)
            hold <= cnt;
        else if (clk_wr)
        begin
            // host loads new bcd values while halted
            case (clk_idx)
                `NVTS_IDX_SEC: hold.sec <= wr_hold.data & wmask;
                `NVTS_IDX_MIN: hold.min <= wr_hold.data & wmask;
                `NVTS_IDX_HOUR: hold.hour <= wr_hold.data & wmask;
                `NVTS_IDX_DAY: hold.day <= wr_hold.data & wmask;
                `NVTS_IDX_DATE: hold.date <= wr_hold.data & wmask;
                `NVTS_IDX_MONTH: hold.month <= wr_hold.data & wmask;
                `NVTS_IDX_YEAR: hold.year <= wr_hold.data & wmask;
                default: hold <= hold; // control handled above
            endcase
        end
    end

    // ==========================================================
    // read path and pins

    logic [7:0] clk_byte; // clock bits at the delayed address
    logic [2:0] rd_idx; // index of the delayed address

    assign rd_idx = addr_d[2:0];

    // pick the clock byte for the location being read
    always_comb
    begin
        case (rd_idx)
            `NVTS_IDX_CTRL: clk_byte = ctrl;
            `NVTS_IDX_SEC: clk_byte = hold.sec;
            `NVTS_IDX_MIN: clk_byte = hold.min;
            `NVTS_IDX_HOUR: clk_byte = hold.hour;
            `NVTS_IDX_DAY: clk_byte = hold.day;
            `NVTS_IDX_DATE: clk_byte = hold.date;
            `NVTS_IDX_MONTH: clk_byte = hold.month;
            default: clk_byte = hold.year;
        endcase
    end

    // ripple-through read: merge array bits with clock bits, then drive
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_d <= 17'h00000;
            byte_lines_out <= 8'h00;
            byte_lines_oe_n <= 1'b1;
            supply_fail_out_n <= 1'b0;
        end
        else
        begin
            addr_d <= addr_s;
            if (is_clk(addr_d))
                byte_lines_out <= (mem_rd & ~clk_mask(rd_idx)) | (clk_byte & clk_mask(rd_idx));
            else
                byte_lines_out <= mem_rd;
            byte_lines_oe_n <= ~rd_drive;
            supply_fail_out_n <= good;
        end
    end

endmodule

// ==== hw/nvts_defines.svh ====
// constants for the timekeeping sram: locations, field masks, timing
// assumes a single 50 mhz clock; included by the package and the top
`ifndef NVTS_DEFINES_SVH
`define NVTS_DEFINES_SVH

// ==========================================================
// array geometry
`define NVTS_ADDR_W 17
`define NVTS_DATA_W 8
`define NVTS_DEPTH 131072
`define NVTS_CLK_TOP 14'h3FFF

// ==========================================================
// clock register index within the top eight locations
`define NVTS_IDX_CTRL 3'h0
`define NVTS_IDX_SEC 3'h1
`define NVTS_IDX_MIN 3'h2
`define NVTS_IDX_HOUR 3'h3
`define NVTS_IDX_DAY 3'h4
`define NVTS_IDX_DATE 3'h5
`define NVTS_IDX_MONTH 3'h6
`define NVTS_IDX_YEAR 3'h7

// ==========================================================
// control bit positions and reset value
`define NVTS_CTRL_WHALT 7
`define NVTS_CTRL_RHALT 6
`define NVTS_CTRL_RESET 8'h00

// ==========================================================
// bits owned by the clock in each location
`define NVTS_MASK_SEC 8'h7F
`define NVTS_MASK_MIN 8'h7F
`define NVTS_MASK_HOUR 8'h3F
`define NVTS_MASK_DAY 8'h07
`define NVTS_MASK_DATE 8'h3F
`define NVTS_MASK_MONTH 8'h1F
`define NVTS_MASK_YEAR 8'hFF

// ==========================================================
// timekeeping reset value: 00-01-01, day 1, 00:00:00
`define NVTS_TIME_RESET {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00}

// ==========================================================
// timing: one second tick derived from the clock rate
`define NVTS_CLK_HZ 50000000
`define NVTS_TICK_MS 1000
`define NVTS_TICK_CYCLES ((`NVTS_CLK_HZ / 1000) * `NVTS_TICK_MS)

`endif

// ==== hw/nvts_pkg.sv ====
// types shared by the timekeeping sram modules
// assumes nvts_defines.svh sits beside it
`include "nvts_defines.svh"

package nvts_pkg;

    // ==========================================================
    // calendar and time, all bcd, year in the top byte
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } nvts_time_t;

    // ==========================================================
    // one sampled host access toward the array
    typedef struct packed {
        logic [`NVTS_ADDR_W-1:0] addr;
        logic [`NVTS_DATA_W-1:0] data;
    } nvts_access_t;

endpackage

// ==== hw/nvts_mem.sv ====
// storage array of the timekeeping sram, one write and one read port
// assumes the top module supplies sampled addresses; read data registered
`timescale 1ns/10ps
`include "nvts_defines.svh"

module nvts_mem
(
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire nvts_pkg::nvts_access_t wr,
    // read port
    input wire logic [`NVTS_ADDR_W-1:0] rd_addr,
    output logic [`NVTS_DATA_W-1:0] rd_data
);
    import nvts_pkg::*;

    // the byte array itself
    logic [`NVTS_DATA_W-1:0] cells [0:`NVTS_DEPTH-1];

    // ==========================================================
    // write port
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            cells[wr.addr] <= wr.data;
        end
    end

    // ==========================================================
    // read port, data out of a register
    always_ff @(posedge clock)
    begin
        rd_data <= cells[rd_addr];
    end

endmodule

// ==== test/nvts_checker.sv ====
// port checker for the timekeeping sram top
// assumes strobes and supply reach outputs through a three edge pipeline, read data through four
`timescale 1ns/10ps

module nvts_checker
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host strobes and address
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [16:0] location_lines,
    // read side
    input wire logic [7:0] byte_lines_out,
    input wire logic byte_lines_oe_n,
    // supply
    input wire logic supply_good,
    input wire logic supply_fail_out_n
);
    // =========================================
    // helpers
    logic rd_req; // enabled read with good supply
    assign rd_req = !ce_n && !oe_n && we_n && supply_good;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // =========================================
    // byte line drive
    drive_cause_a: assert property (
        !byte_lines_oe_n |-> $past(rd_req, 3))
        else $error("byte lines driven without read");
    drive_on_a: assert property (
        rd_req [*4] |-> !byte_lines_oe_n)
        else $error("read not driven");
    drive_off_a: assert property (
        ce_n |-> ##3 byte_lines_oe_n)
        else $error("drive kept after deselect");
    write_quiet_a: assert property (
        !we_n |-> ##3 byte_lines_oe_n)
        else $error("drive during write");
    read_steady_a: assert property (
        ($stable(location_lines) && we_n && location_lines < 17'h1FFF8) [*8]
        |-> $stable(byte_lines_out))
        else $error("ram read data moved");

    // =========================================
    // supply monitor
    fail_low_a: assert property (
        !supply_good |-> ##3 !supply_fail_out_n)
        else $error("fail output not low");
    fail_rise_a: assert property (
        $rose(supply_fail_out_n) |-> $past(supply_good, 3))
        else $error("fail output rose early");
    fail_quiet_a: assert property (
        !supply_fail_out_n |-> byte_lines_oe_n)
        else $error("drive during supply fail");

    // main scenarios
    read_c: cover property (!byte_lines_oe_n);
    write_c: cover property (!ce_n && !we_n);
    fail_c: cover property (!supply_fail_out_n && !supply_good);
endmodule

bind nvts_top nvts_checker chk_u
(
    .clock(clock), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .location_lines(location_lines), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n), .supply_good(supply_good),
    .supply_fail_out_n(supply_fail_out_n)
);

// ==== test/nvts_host_model.sv ====
// host processor model driving plain async sram cycles
// assumes the device samples pins on the rising clock edge
`timescale 1ns/10ps

module nvts_host_model
(
    // clock
    input wire logic clock,
    // pins toward the device
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [16:0] location_lines,
    output logic [7:0] byte_lines_in,
    // answer
    input wire logic [7:0] byte_lines_out,
    input wire logic byte_lines_oe_n
);
    // idle bus at time zero
    initial
    begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        location_lines = 17'h00000;
        byte_lines_in = 8'hA5;
    end

    // write: address and data held whole cycle, gap after
    task automatic write_byte(input logic [16:0] a, input logic [7:0] d);
        @(negedge clock);
        location_lines = a;
        byte_lines_in = d;
        ce_n = 1'b0;
        we_n = 1'b0;
        repeat (4) @(negedge clock);
        we_n = 1'b1;
        ce_n = 1'b1;
        repeat (5) @(negedge clock);
        byte_lines_in = ~d; // released bus shows no stale value
    endtask

    // read: data taken once the pipeline has settled
    task automatic read_byte(input logic [16:0] a, input logic oe,
                             output logic [7:0] d, output logic drv);
        @(negedge clock);
        location_lines = a;
        ce_n = 1'b0;
        oe_n = oe;
        repeat (5) @(negedge clock);
        drv = !byte_lines_oe_n;
        d = drv ? byte_lines_out : ~byte_lines_out;
        ce_n = 1'b1;
        oe_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask
endmodule

// ==== test/nvts_tb_top.sv ====
// self-checking bench for the timekeeping sram
// assumes checker bound to the top, host model beside it
`timescale 1ns/10ps

module nvts_tb_top;
    import nvts_pkg::*;
    localparam int TICK = 100; // short second tick
    localparam logic [16:0] CTRL = 17'h1FFF8;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic supply_good = 1'b1;
    logic ce_n, oe_n, we_n, byte_lines_oe_n, supply_fail_out_n, drv;
    logic [16:0] location_lines;
    logic [16:0] a;
    logic [7:0] byte_lines_in, byte_lines_out, rd;
    logic [7:0] snap [7];
    logic [7:0] mem [int]; // ram model
    logic [31:0] seed = 32'h222A31FD;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int t0;
    int tm [7]; // model time: sec min hour day date month year
    int cases [4][7] = '{'{59, 59, 23, 7, 28, 2, 0}, '{59, 59, 23, 7, 28, 2, 1},
                         '{59, 59, 23, 7, 31, 12, 99}, '{59, 59, 23, 3, 30, 4, 5}};

    nvts_top #(.TICK_CYCLES(TICK)) dut_u
    (
        .clock(clock), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .location_lines(location_lines), .byte_lines_in(byte_lines_in),
        .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n),
        .supply_good(supply_good), .supply_fail_out_n(supply_fail_out_n)
    );
    nvts_host_model host_u
    (
        .clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .location_lines(location_lines), .byte_lines_in(byte_lines_in),
        .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n)
    );

    // =========================================
    // clock and timeout
    always #10 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // =========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    // one second of the calendar model
    function automatic void step();
        int ml;
        ml = (tm[5] == 2) ? ((tm[6] % 4 == 0) ? 29 : 28) :
             ((tm[5] inside {4, 6, 9, 11}) ? 30 : 31);
        if (++tm[0] < 60) return;
        tm[0] = 0;
        if (++tm[1] < 60) return;
        tm[1] = 0;
        if (++tm[2] < 24) return;
        tm[2] = 0;
        tm[3] = tm[3] % 7 + 1;
        if (++tm[4] <= ml) return;
        tm[4] = 1;
        if (++tm[5] <= 12) return;
        tm[5] = 1;
        tm[6] = (tm[6] + 1) % 100;
    endfunction
    // snapshot against model; month bit 7 is a storage bit set by us
    function automatic bit same();
        for (int i = 0; i < 7; i++)
            if (snap[i] !== (bcd(tm[i]) | (i == 5 ? 8'h80 : 8'h00))) return 1'b0;
        return 1'b1;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [16:0] adr, input logic [7:0] exp);
        host_u.read_byte(adr, 1'b0, rd, drv);
        check(rd, exp);
    endtask
    // read all time locations, allow one tick of phase slack
    task automatic clock_check(input int base [7]);
        int n;
        n = (cyc - t0) / TICK;
        for (int i = 0; i < 7; i++) host_u.read_byte(CTRL + 17'(i + 1), 1'b0, snap[i], drv);
        tm = base;
        repeat (n) step();
        if (!same()) step();
        check({7'h00, same()}, 8'h01);
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // =========================================
    // main sequence
    initial
    begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        check({7'h00, supply_fail_out_n}, 8'h01);
        rchk(CTRL, 8'h00);
        // ram writes back to back, then read back
        mem[0] = 8'h3C;
        mem[32'h1FFF7] = 8'hC3;
        repeat (8) mem[rnd() % 32'h1FFF8] = rnd() & 8'hFF;
        foreach (mem[i]) host_u.write_byte(17'(i), mem[i]);
        foreach (mem[i]) rchk(17'(i), mem[i]);
        host_u.read_byte(17'h00000, 1'b1, rd, drv);
        check({7'h00, drv}, 8'h00);
        // control bits read back at once
        host_u.write_byte(CTRL, 8'h2A);
        rchk(CTRL, 8'h2A);
        // set the clock, let it run, freeze and compare
        foreach (cases[c])
        begin
            host_u.write_byte(CTRL, 8'h80);
            for (int i = 0; i < 7; i++)
                host_u.write_byte(CTRL + 17'(i + 1), bcd(cases[c][i]) | (i == 5 ? 8'h80 : 8'h00));
            host_u.write_byte(CTRL, 8'h00);
            t0 = cyc;
            repeat (140) @(negedge clock);
            host_u.write_byte(CTRL, 8'h40);
            clock_check(cases[c]);
            repeat (250) @(negedge clock);
            rchk(CTRL + 17'h00001, snap[0]);
            rchk(CTRL, 8'h40);
            host_u.write_byte(CTRL, 8'h00);
            repeat (60) @(negedge clock);
            host_u.write_byte(CTRL, 8'h40);
            clock_check(cases[c]);
        end
        // supply fail blocks access
        a = 17'h00100;
        host_u.write_byte(a, 8'h5A);
        supply_good = 1'b0;
        repeat (4) @(negedge clock);
        check({7'h00, supply_fail_out_n}, 8'h00);
        host_u.write_byte(a, 8'hA5);
        host_u.read_byte(a, 1'b0, rd, drv);
        check({7'h00, drv}, 8'h00);
        supply_good = 1'b1;
        repeat (4) @(negedge clock);
        check({7'h00, supply_fail_out_n}, 8'h01);
        rchk(a, 8'h5A);
        // reset again in mid-run: control and seconds back to reset values
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        check({7'h00, supply_fail_out_n}, 8'h01);
        rchk(CTRL, 8'h00);
        rchk(CTRL + 17'h00001, 8'h00);
        finish_test();
    end
endmodule
